// File: hdl/dlupd_pkg.sv
package dlupd_pkg;
   localparam int          NCH          = 8;
   localparam int          DW           = 12;
   localparam int          AW           = 5;
   localparam int          CLK_MHZ      = 10;
   // Device register addresses on the parallel port
   localparam logic [4:0]  A_CFG        = 5'h00;
   localparam logic [4:0]  A_MON        = 5'h01;
   localparam logic [4:0]  A_CH0        = 5'h08;
   // Configuration word fields
   localparam int          B_SOFT_LOAD  = 10;
   localparam int          B_PD_A       = 8;
   localparam int          B_PD_B       = 7;
   localparam int          B_CORR_EN    = 6;
   localparam int          B_GBF        = 5;
   // Power-on values of data register and latch, by reset_value_select, and the monitor-off selection
   localparam logic [11:0] RST_VAL_LO   = 12'h000;
   localparam logic [11:0] RST_VAL_HI   = 12'h800;
   localparam logic [11:0] MON_OFF      = 12'h000;
   // Timing
   localparam int          REC_US       = 200;
   localparam int          REC_CYC      = REC_US * CLK_MHZ;
   localparam int          CAL_CYC      = 16;
   localparam int          BOOT_CYC     = 3;
   localparam int          CS_LOW_CYC   = 8;
   localparam int          LOAD_STROBE_N_LOW_CYC = 4;
   // Host register byte addresses on AXI4-Lite
   localparam logic [3:0]  H_CMD        = 4'h0;
   localparam logic [3:0]  H_PINS       = 4'h4;
   localparam int          B_PIN_LOAD_STROBE_N   = 0;
   localparam int          B_PIN_CLR    = 1;
   localparam int          B_PIN_RST    = 2;
   localparam int          B_PIN_RSEL   = 3;
   localparam logic [3:0]  H_STAT       = 4'h8;
   localparam logic [3:0]  H_PULSE      = 4'hc;
   localparam int          C_ADDR_LSB   = 16;
   localparam int          C_READ       = 24;
   localparam logic [31:0] PINS_RST     = 32'h0000_000f;
   localparam logic [1:0]  RESP_OK      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// File: hdl/dlupd_if.sv
`timescale 1ns/1ns
interface dlupd_if;
   import dlupd_pkg::*;
   // Parallel port, host driven except rdata
   logic          cs_n;
   logic          rw;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   // Strobes and straps, host driven
   logic          load_strobe_n;
   logic          clear_n;
   logic          rst_n;
   logic          reset_value_select;
   // Open-drain busy and tri-state monitor
   logic          busy_o;
   logic          busy_oe_n;
   logic          busy;
   logic          monitor_oe_n;
   logic [DW-1:0] monitor_sel;
   logic          monitor_active;

   // Busy line has a pull-up; enable low means the device pulls it
   assign busy           = busy_oe_n ? 1'b1 : busy_o;
   assign monitor_active = ~monitor_oe_n;

   modport dev (input cs_n, rw, addr, wdata, load_strobe_n, clear_n, rst_n,
                input reset_value_select,
                output rdata, busy_o, busy_oe_n, monitor_oe_n, monitor_sel);
   modport host (output cs_n, rw, addr, wdata, load_strobe_n, clear_n, rst_n,
                 output reset_value_select,
                 input rdata, busy, monitor_active);
endinterface

// File: hdl/dlupd_sync.sv
`timescale 1ns/1ns
module dlupd_sync #(
   parameter int          W   = 1,
   parameter logic [W-1:0] INI = '0
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Pins in, synchronised out
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= INI;
         q    <= INI;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// File: hdl/dlupd_device.sv
`timescale 1ns/1ns
// Operation
// - Update mode fixed once at power-on
// - Host straps load strobe low or high
// - Reload only channels written since last load
// - Loaded latch drives output at once
// - Async mode ignores soft load and strobe
// - Async, no correction: load on chip-select rise
// - Async, correction: load per channel on engine write
// - Sync, no correction: event loads all pending
// - Sync, correction idle: event loads all pending
// - Sync, engine busy: defer load until idle
// - Sync, no event: latches stay unchanged
// - Host waits t15/t18 before strobe pulse, t15 only before soft load
// - Monitor selection routes chosen node out
// - Monitor disabled means high-impedance output
// - Host enables one monitor per shared line
// - Powered-down group grounded, buffer high-impedance
// - Bus stays usable while powered down
// - Group recovers within 200 us of clear
// - Initialization pin levels latched at power-on
// - Busy flag and busy pin while correcting
// - Strobe pulses ignored while clear held low
module dlupd_device
   import dlupd_pkg::*;
(
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // Device pins
   dlupd_if.dev                     pins,
   // Channel outputs
   output      logic [NCH-1:0][DW-1:0] ch_level,
   output      logic [NCH-1:0]      ch_hiz,
   output      logic [NCH-1:0]      ch_gnd,
   output      logic                async_mode
);
   import dlupd_pkg::*;

   typedef struct packed {
      logic [1:0]             boot;
      logic                   booted;
      logic                   async_m;
      logic [DW-1:0]          rst_val;
      logic                   cs_q;
      logic                   ld_q;
      logic [AW-1:0]          addr;
      logic [DW-1:0]          wdata;
      logic                   pd_a;
      logic                   pd_b;
      logic                   corr_en;
      logic [DW-1:0]          mon;
      logic [NCH-1:0][DW-1:0] inreg;
      logic [NCH-1:0][DW-1:0] dreg;
      logic [NCH-1:0][DW-1:0] latch;
      logic [NCH-1:0]         pend;
      logic [NCH-1:0]         cpend;
      logic                   eng_run;
      logic [2:0]             eng_ch;
      logic [7:0]             eng_cnt;
      logic                   defer;
      logic [1:0][11:0]       rec_cnt;
      logic [DW-1:0]          rdata;
      logic [NCH-1:0]         hiz;
      logic [NCH-1:0]         gnd;
      logic                   busy_oe_n;
   } dlupd_dev_t;

   dlupd_dev_t st;
   dlupd_dev_t next_st;

   logic          s_cs_n;
   logic          s_rw;
   logic [AW-1:0] s_addr;
   logic [DW-1:0] s_wdata;
   logic          s_ld_n;
   logic          s_clr_n;
   logic          s_rst_n;
   logic          s_rsel;

   // Every pin crosses two flops; bus bits are stable long before the cs edge
   dlupd_sync #(.W(23), .INI(23'h7c_0000)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({pins.cs_n, pins.load_strobe_n, pins.clear_n, pins.rst_n,
                 pins.rw, pins.reset_value_select, pins.addr, pins.wdata}),
      .q       ({s_cs_n, s_ld_n, s_clr_n, s_rst_n, s_rw, s_rsel, s_addr, s_wdata})
   );

   function automatic logic is_ch(input logic [AW-1:0] a);
      return a[AW-1:3] == A_CH0[AW-1:3];
   endfunction

   logic          commit;
   logic          cfg_wr;
   logic          ev;
   logic          global_busy_flag;
   logic          load_all;
   logic          eng_done;
   logic [NCH-1:0] wr_ch;
   logic [NCH-1:0] loaded;
   logic [1:0]    pd;

   always_comb begin
      next_st  = st;
      commit   = st.booted && s_rst_n && !st.cs_q && s_cs_n && !s_rw;
      cfg_wr   = commit && st.addr == A_CFG;
      global_busy_flag      = st.eng_run || (|st.cpend);
      ev       = !st.async_m && st.booted &&
                 ((st.ld_q && !s_ld_n && s_clr_n) ||
                  (cfg_wr && st.wdata[B_SOFT_LOAD]));
      load_all = !st.async_m && (ev || st.defer) && !global_busy_flag;
      eng_done = st.eng_run && st.eng_cnt == 8'(CAL_CYC - 1);
      wr_ch    = '0;
      loaded   = '0;
      next_st.cs_q = s_cs_n;
      next_st.ld_q = s_ld_n;

      // Straps are caught once, after the synchronisers have filled
      if (!st.booted) begin
         next_st.boot = st.boot + 2'd1;
         if (st.boot == 2'(BOOT_CYC - 1)) begin
            next_st.booted  = 1'b1;
            next_st.async_m = !s_ld_n;
            next_st.rst_val = s_rsel ? RST_VAL_HI : RST_VAL_LO;
            for (int i = 0; i < NCH; i++) begin
               next_st.dreg[i]  = s_rsel ? RST_VAL_HI : RST_VAL_LO;
               next_st.latch[i] = s_rsel ? RST_VAL_HI : RST_VAL_LO;
            end
         end
      end

      // Bus is decoded regardless of power-down state
      if (!s_cs_n) begin
         next_st.addr  = s_addr;
         next_st.wdata = s_wdata;
         if (s_rw) begin
            if (s_addr == A_CFG) begin
               next_st.rdata = '0;
               next_st.rdata[B_PD_A]    = st.pd_a;
               next_st.rdata[B_PD_B]    = st.pd_b;
               next_st.rdata[B_CORR_EN] = st.corr_en;
               next_st.rdata[B_GBF]     = global_busy_flag;
            end else if (s_addr == A_MON) begin
               next_st.rdata = st.mon;
            end else if (is_ch(s_addr)) begin
               next_st.rdata = st.dreg[s_addr[2:0]];
            end else begin
               next_st.rdata = '0;
            end
         end
      end

      if (cfg_wr) begin
         next_st.pd_a    = st.wdata[B_PD_A];
         next_st.pd_b    = st.wdata[B_PD_B];
         next_st.corr_en = st.wdata[B_CORR_EN];
      end
      if (commit && st.addr == A_MON) begin
         next_st.mon = st.wdata;
      end

      // Sync-mode group load uses the old data registers
      if (ev && global_busy_flag) begin
         next_st.defer = 1'b1;
      end
      if (load_all) begin
         next_st.defer = 1'b0;
         loaded        = st.pend;
         for (int i = 0; i < NCH; i++) begin
            if (st.pend[i]) begin
               next_st.latch[i] = st.dreg[i];
            end
         end
      end

      if (commit && is_ch(st.addr)) begin
         wr_ch[st.addr[2:0]] = 1'b1;
         if (st.corr_en) begin
            next_st.inreg[st.addr[2:0]] = st.wdata;
         end else begin
            next_st.dreg[st.addr[2:0]] = st.wdata;
            if (st.async_m) begin
               next_st.latch[st.addr[2:0]] = st.wdata;
               loaded[st.addr[2:0]]        = 1'b1;
            end
         end
      end

      // Correction engine works one channel at a time
      if (eng_done) begin
         next_st.eng_run            = 1'b0;
         next_st.dreg[st.eng_ch]    = st.inreg[st.eng_ch];
         if (st.async_m) begin
            next_st.latch[st.eng_ch] = st.inreg[st.eng_ch];
         end
      end else if (st.eng_run) begin
         next_st.eng_cnt = st.eng_cnt + 8'd1;
      end else begin
         for (int i = NCH - 1; i >= 0; i--) begin
            if (st.cpend[i]) begin
               next_st.eng_ch = 3'(i);
            end
         end
         next_st.eng_run = |st.cpend;
         next_st.eng_cnt = '0;
      end

      // Set beats clear in cpend; in pend, a load clears a write of the same cycle
      next_st.cpend = (st.cpend & ~((eng_done && !st.eng_run) ? '0 :
                      (NCH'(eng_done) << st.eng_ch))) | (st.corr_en ? wr_ch : '0);
      next_st.pend  = ((st.pend & ~loaded) |
                      (st.corr_en ? '0 : (wr_ch & ~loaded)) |
                      ((eng_done && !st.async_m) ? NCH'(1) << st.eng_ch : '0));

      // Group power-down and timed recovery
      pd = {st.pd_b, st.pd_a};
      for (int g = 0; g < 2; g++) begin
         if (pd[g]) begin
            next_st.rec_cnt[g] = 12'(REC_CYC - 1);
         end else if (st.rec_cnt[g] != '0) begin
            next_st.rec_cnt[g] = st.rec_cnt[g] - 12'd1;
         end
      end
      for (int i = 0; i < NCH; i++) begin
         next_st.hiz[i] = pd[i / 4] || st.rec_cnt[i / 4] != '0;
         next_st.gnd[i] = next_st.hiz[i] || !s_clr_n;
      end
      next_st.busy_oe_n = !(next_st.eng_run || (|next_st.cpend));

      // Hardware reset pin restores strapped values and blocks bus writes
      if (!s_rst_n && st.booted) begin
         next_st.inreg   = '0;
         next_st.pend    = '0;
         next_st.cpend   = '0;
         next_st.eng_run = 1'b0;
         next_st.defer   = 1'b0;
         for (int i = 0; i < NCH; i++) begin
            next_st.dreg[i]  = st.rst_val;
            next_st.latch[i] = st.rst_val;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st           <= '0;
         st.cs_q      <= 1'b1;
         st.ld_q      <= 1'b1;
         st.hiz       <= '1;
         st.gnd       <= '1;
         st.busy_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign ch_level          = st.latch;
   assign ch_hiz            = st.hiz;
   assign ch_gnd            = st.gnd;
   assign async_mode        = st.async_m;
   assign pins.rdata        = st.rdata;
   assign pins.busy_o       = st.boot[1] & 1'b0;
   assign pins.busy_oe_n    = st.busy_oe_n;
   // Only one device per shared line should have a nonzero selection
   assign pins.monitor_oe_n = st.mon == MON_OFF;
   assign pins.monitor_sel  = st.mon;
endmodule

// File: hdl/dlupd_host.sv
`timescale 1ns/1ns
module dlupd_host
   import dlupd_pkg::*;
#(
   parameter int T15_NS = 1000,
   parameter int T18_NS = 1000
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output      logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output      logic        wready,
   output      logic [1:0]  bresp,
   output      logic        bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output      logic        arready,
   output      logic [31:0] rdata,
   output      logic [1:0]  rresp,
   output      logic        rvalid,
   input  wire logic        rready,
   // Device pins
   dlupd_if.host            pins
);
   import dlupd_pkg::*;

   localparam int T15_CYC = (T15_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                            (T15_NS * CLK_MHZ + 999) / 1000;
   localparam int T18_CYC = (T18_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                            (T18_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_GAP} dlupd_hs_t;

   typedef struct packed {
      dlupd_hs_t     hs;
      logic [15:0]   cnt;
      logic [15:0]   bcnt;
      logic [7:0]    pcnt;
      logic          pulse_req;
      logic          aw_got;
      logic          w_got;
      logic [3:0]    wa;
      logic [31:0]   wd;
      logic [31:0]   pinreg;
      logic [DW-1:0] rd_cap;
      logic          busy_q;
      logic          cs_n;
      logic          rw;
      logic [AW-1:0] addr;
      logic [DW-1:0] dout;
      logic          ld_n;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } dlupd_host_t;

   dlupd_host_t st;
   dlupd_host_t next_st;
   logic [DW-1:0] s_rdata;
   logic          s_busy;

   dlupd_sync #(.W(13), .INI(13'h1000)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({pins.busy, pins.rdata}),
      .q       ({s_busy, s_rdata})
   );

   function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            o[8*b +: 8] = n[8*b +: 8];
         end
      end
      return o;
   endfunction

   always_comb begin
      next_st        = st;
      next_st.busy_q = s_busy;
      if (st.bcnt != '0) begin
         next_st.bcnt = st.bcnt - 16'd1;
      end
      if (s_busy && !st.busy_q) begin
         next_st.bcnt = 16'(T18_CYC);
      end
      if (awvalid && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.wa     = awaddr;
      end
      if (wvalid && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.wd    = lanes(32'h0, wdata, wstrb);
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end

      // Bus cycle sequencer; cs stays low long enough for pin synchronisers
      unique case (st.hs)
         HS_IDLE: begin
            next_st.cs_n = 1'b1;
         end
         HS_LOW: begin
            next_st.cnt = st.cnt - 16'd1;
            if (st.cnt == 16'd1) begin
               next_st.cs_n   = 1'b1;
               next_st.rd_cap = st.rw ? s_rdata : st.rd_cap;
               next_st.hs     = HS_GAP;
               next_st.cnt    = 16'(T15_CYC);
            end
         end
         HS_GAP: begin
            next_st.cnt = st.cnt - 16'd1;
            if (st.cnt == 16'd1) begin
               next_st.hs = HS_IDLE;
            end
         end
      endcase

      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = RESP_OK;
         unique case (st.wa)
            H_CMD: begin
               if (st.hs == HS_IDLE && st.pcnt == '0) begin
                  next_st.hs   = HS_LOW;
                  next_st.cnt  = 16'(CS_LOW_CYC);
                  next_st.cs_n = 1'b0;
                  next_st.rw   = st.wd[C_READ];
                  next_st.addr = st.wd[C_ADDR_LSB +: AW];
                  next_st.dout = st.wd[DW-1:0];
               end
            end
            H_PINS:  next_st.pinreg = st.wd;
            H_PULSE: next_st.pulse_req = next_st.pulse_req | st.wd[0];
            default: next_st.bresp = RESP_SLVERR;
         endcase
      end

      // Load pulse only after both settling gaps have run out
      if (st.pcnt != '0) begin
         next_st.pcnt = st.pcnt - 8'd1;
      end else if (st.pulse_req && st.hs == HS_IDLE && st.bcnt == '0 && s_busy) begin
         next_st.pulse_req = 1'b0;
         next_st.pcnt      = 8'(LOAD_STROBE_N_LOW_CYC);
      end
      next_st.ld_n = next_st.pinreg[B_PIN_LOAD_STROBE_N] && next_st.pcnt == '0;

      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      next_st.arready = 1'b0;
      if (arvalid && !st.rvalid && !st.arready) begin
         next_st.arready = 1'b1;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = RESP_OK;
         unique case (araddr)
            H_CMD:   next_st.rdata = {7'h0, st.rw, 3'h0, st.addr, 4'h0, st.dout};
            H_PINS:  next_st.rdata = st.pinreg;
            H_STAT:  next_st.rdata = {4'h0, st.rd_cap, 12'h0, st.pcnt != '0,
                                      st.pulse_req, s_busy, st.hs != HS_IDLE};
            default: begin
               next_st.rdata = '0;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      next_st.awready = !next_st.aw_got && !next_st.bvalid;
      next_st.wready  = !next_st.w_got && !next_st.bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st        <= '0;
         st.hs     <= HS_IDLE;
         st.pinreg <= PINS_RST;
         st.cs_n   <= 1'b1;
         st.ld_n   <= PINS_RST[B_PIN_LOAD_STROBE_N];
         st.busy_q <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign awready                 = st.awready;
   assign wready                  = st.wready;
   assign bvalid                  = st.bvalid;
   assign bresp                   = st.bresp;
   assign arready                 = st.arready;
   assign rvalid                  = st.rvalid;
   assign rdata                   = st.rdata;
   assign rresp                   = st.rresp;
   assign pins.cs_n               = st.cs_n;
   assign pins.rw                 = st.rw;
   assign pins.addr               = st.addr;
   assign pins.wdata              = st.dout;
   assign pins.load_strobe_n      = st.ld_n;
   assign pins.clear_n            = st.pinreg[B_PIN_CLR];
   assign pins.rst_n              = st.pinreg[B_PIN_RST];
   assign pins.reset_value_select = st.pinreg[B_PIN_RSEL];
endmodule

// File: tb/dlupd_monitor.sv
`timescale 1ns/1ns
module dlupd_monitor
   import dlupd_pkg::*;
(
   // Clock and reset
   input wire logic          aclk,
   input wire logic          aresetn,
   // Link signals
   input wire logic          cs_n,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic          load_strobe_n,
   input wire logic          busy_o,
   input wire logic          busy_oe_n,
   input wire logic          busy,
   input wire logic          monitor_oe_n,
   input wire logic [DW-1:0] monitor_sel
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Three cycles of stable select allow for a registered enable
   chk_mon_off: assert property ((monitor_sel == MON_OFF) [*3] |-> monitor_oe_n)
      else $error("monitor drives while off");
   chk_mon_on: assert property ((monitor_sel != MON_OFF) [*3] |-> !monitor_oe_n)
      else $error("monitor idle while selected");
   chk_busy_pull: assert property (!busy_oe_n |-> !busy_o && !busy)
      else $error("busy line not low");
   chk_ld_gap: assert property ($rose(cs_n) |-> !$fell(load_strobe_n) [*8])
      else $error("strobe soon after cycle");
   chk_ld_wait: assert property ($rose(busy) |-> !$fell(load_strobe_n) [*8])
      else $error("strobe soon after busy");
   chk_ld_idle: assert property ($fell(load_strobe_n) |-> cs_n && busy)
      else $error("strobe while busy");
   chk_cs_hold: assert property (!cs_n && $past(!cs_n) |-> $stable(addr) && $stable(wdata))
      else $error("cycle payload moved");
   chk_cs_width: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
      else $error("cycle length wrong");
   chk_boot_quiet: assert property ($rose(aresetn) |-> busy_oe_n && monitor_oe_n)
      else $error("outputs active at boot");
   cover property ($fell(load_strobe_n));
   cover property (!busy_oe_n);
   cover property (!monitor_oe_n);
endmodule

// File: tb/dlupd_tb_top.sv
`timescale 1ns/1ns
module dac_latch_update_and_powerdown_tb_top;
   import dlupd_pkg::*;
   logic                   aclk = 1'h0;
   logic                   aresetn = 1'h0;
   logic                   dev_resetn = 1'h0;
   logic [3:0]             awaddr = '0, araddr = '0, wstrb = 4'hf;
   logic [31:0]            wdata = '0, rdata, st;
   logic                   awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                   arvalid = 1'h0, rready = 1'h0;
   logic                   awready, wready, bvalid, arready, rvalid, async_mode;
   logic [1:0]             bresp, rresp, rr;
   logic [NCH-1:0][DW-1:0] ch_level;
   logic [NCH-1:0]         ch_hiz, ch_gnd;
   logic [DW-1:0]          lv [NCH];
   int                     fail_count = 0, num_checks = 0;
   dlupd_if io ();
   always #50 aclk = ~aclk;
   dlupd_host u_dlupd_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(io));
   // Separate device reset lets the strap be changed while the host keeps running
   dlupd_device u_dlupd_device (.aclk(aclk), .aresetn(dev_resetn), .pins(io),
      .ch_level(ch_level), .ch_hiz(ch_hiz), .ch_gnd(ch_gnd), .async_mode(async_mode));
   dlupd_monitor u_dlupd_monitor (.aclk(aclk), .aresetn(dev_resetn), .cs_n(io.cs_n),
      .addr(io.addr), .wdata(io.wdata), .load_strobe_n(io.load_strobe_n),
      .busy_o(io.busy_o), .busy_oe_n(io.busy_oe_n), .busy(io.busy),
      .monitor_oe_n(io.monitor_oe_n), .monitor_sel(io.monitor_sel));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      // One edge between calls so no handshake signal is assigned twice at once
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
   endtask
   task automatic axr(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      st = rdata;
      rr = rresp;
      rready <= 1'h0;
   endtask
   task automatic idle(input logic [31:0] m);
      repeat (2) @(posedge aclk);
      do axr(H_STAT); while ((st & m) != '0);
      repeat (6) @(posedge aclk);
   endtask
   task automatic devw(input logic [4:0] a, input logic [11:0] d);
      axw(H_CMD, {11'h000, a, 4'h0, d});
      idle(32'h1);
   endtask
   task automatic ldp();
      axw(H_PULSE, 32'h1);
      idle(32'hd);
   endtask
   task automatic allch();
      for (int i = 0; i < NCH; i++) chk(32'(ch_level[i]), 32'(lv[i]));
   endtask
   task automatic t_boot();
      foreach (lv[i]) lv[i] = RST_VAL_HI;
      allch();
      chk(32'(ch_hiz), '0);
      axr(4'h2);
      chk(32'(rr), 32'(RESP_SLVERR));
      devw(A_MON, 12'h001);
      chk(32'(io.monitor_active), 32'h1);
      devw(A_MON, MON_OFF);
      chk(32'(io.monitor_active), 32'h0);
   endtask
   task automatic t_sync();
      devw(A_CH0, 12'h123);
      devw(A_CH0 + 5'h2, 12'h456);
      allch();
      ldp();
      lv[0] = 12'h123;
      lv[2] = 12'h456;
      allch();
      devw(A_CH0 + 5'h1, 12'h0ab);
      devw(A_CFG, 12'h400);
      lv[1] = 12'h0ab;
      allch();
   endtask
   task automatic t_clear();
      devw(A_CH0 + 5'h3, 12'h321);
      axw(H_PINS, 32'hd);
      repeat (4) @(posedge aclk);
      ldp();
      allch();
      chk(32'(ch_gnd), 32'hff);
      axw(H_PINS, PINS_RST);
      repeat (4) @(posedge aclk);
      ldp();
      lv[3] = 12'h321;
      allch();
      chk(32'(ch_gnd), '0);
   endtask
   task automatic t_pd();
      devw(A_CFG, 12'h100);
      chk(32'(ch_hiz), 32'hf);
      chk(32'(ch_gnd), 32'hf);
      devw(A_CH0 + 5'h1, 12'h5a5);
      ldp();
      lv[1] = 12'h5a5;
      allch();
      axw(H_CMD, 32'h0109_0000);
      idle(32'h1);
      axr(H_STAT);
      chk(32'(st[27:16]), 32'h5a5);
      devw(A_CFG, 12'h000);
      repeat (REC_CYC) @(posedge aclk);
      chk(32'(ch_hiz), '0);
   endtask
   task automatic t_corr();
      devw(A_CFG, 12'h040);
      devw(A_CH0 + 5'h5, 12'h777);
      allch();
      ldp();
      lv[5] = 12'h777;
      allch();
   endtask
   task automatic t_async();
      dev_resetn <= 1'h0;
      axw(H_PINS, 32'he);
      repeat (4) @(posedge aclk);
      dev_resetn <= 1'h1;
      repeat (BOOT_CYC + 4) @(posedge aclk);
      foreach (lv[i]) lv[i] = RST_VAL_HI;
      devw(A_CH0 + 5'h6, 12'h6c6);
      lv[6] = 12'h6c6;
      allch();
      axw(H_PINS, PINS_RST);
      chk(32'(async_mode), 32'h1);
      devw(A_CFG, 12'h440);
      devw(A_CH0 + 5'h7, 12'h1e1);
      do @(posedge aclk); while (io.busy !== 1'h1);
      repeat (4) @(posedge aclk);
      lv[7] = 12'h1e1;
      allch();
   endtask
   task automatic end_sim();
      if (fail_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      dev_resetn <= 1'h1;
      repeat (BOOT_CYC + 4) @(posedge aclk);
      t_boot();
      t_sync();
      t_clear();
      t_pd();
      t_corr();
      t_async();
      end_sim();
   end
endmodule
